// ==== shared/monitor_cfg.svh ====
/*
  constants of the clock frequency accuracy monitor: source codes,
  divider and filter encodings, limits and reset values.
  assumes it is included by bare name after the type package.

// Notes on behaviour
// - overflow raises its request only while overflow enable is set
// - frequency error raises a request only while its enable is set
// - 16-bit upper limit; a count above it is not acceptable
// - 16-bit lower limit; a count below it is not acceptable
// - reference and measurement clocks each pick one of seven sources
// - period is delimited by rising, falling or both reference edges
// - reference filter off, or sampling at measuring rate, /4 or /16
// - count divided measurement ticks over one period, then compare limits
// - in-range finish raises measurement-end request while enabled
// - overflow is signalled when the counter passes 0xFFFF
// - continuous mode restarts after each result; single mode stops
*/
`ifndef MONITOR_CFG_SVH
`define MONITOR_CFG_SVH

`define SRC_MAIN_OSC 3'h0
`define SRC_SUB_CLOCK 3'h1
`define SRC_HIGH_SPEED_OSC 3'h2
`define SRC_MID_SPEED_OSC 3'h3
`define SRC_LOW_SPEED_OSC 3'h4
`define SRC_PERIPHERAL_BUS 3'h5
`define SRC_WATCHDOG_OSC 3'h6
`define SRC_COUNT 7

`define REF_DIV_32 2'h0
`define REF_DIV_128 2'h1
`define REF_DIV_1024 2'h2
`define REF_DIV_8192 2'h3
`define REF_HALF_32 12'h00f
`define REF_HALF_128 12'h03f
`define REF_HALF_1024 12'h1ff
`define REF_HALF_8192 12'hfff

`define MEAS_DIV_1 2'h0
`define MEAS_DIV_4 2'h1
`define MEAS_DIV_8 2'h2
`define MEAS_DIV_32 2'h3
`define MEAS_TERM_1 5'h00
`define MEAS_TERM_4 5'h03
`define MEAS_TERM_8 5'h07
`define MEAS_TERM_32 5'h1f

`define EDGE_RISE 2'h0
`define EDGE_FALL 2'h1
`define EDGE_BOTH 2'h2

`define FILTER_OFF 2'h0
`define FILTER_FULL 2'h1
`define FILTER_DIV4 2'h2
`define FILTER_DIV16 2'h3
`define FILTER_TERM_FULL 4'h0
`define FILTER_TERM_DIV4 4'h3
`define FILTER_TERM_DIV16 4'hf

`define COUNT_MAX 16'hffff
`define COUNT_RESET 16'h0000

`endif

// ==== shared/monitor_pkg.sv ====
/*
  types of the clock frequency accuracy monitor.
  assumes nothing of its surroundings.
*/
package monitor_pkg;

  typedef enum logic [2:0]
  {
    PHASE_IDLE = 3'h1,
    PHASE_ARM = 3'h2,
    PHASE_COUNT = 3'h4
  } phase_type;

  typedef struct packed
  {
    logic [6:0] stage1;
    logic [6:0] stage2;
    logic [6:0] stage3;
    logic [6:0] seen;
    logic rise;
    logic fall;
  } tap_state_type;

  typedef struct packed
  {
    phase_type phase;
    logic done;
    logic [11:0] ref_div;
    logic ref_div_level;
    logic [4:0] meas_div;
    logic [3:0] filt_div;
    logic filt_sample;
    logic ref_level;
    logic [15:0] count;
    logic [15:0] result;
    logic meas_end_flag;
    logic freq_err_flag;
    logic overflow_flag;
    logic meas_end_irq;
    logic freq_err_irq;
    logic overflow_irq;
  } monitor_state_type;

endpackage

// ==== shared/edge_if.sv ====
/*
  edge pulses of one selected clock source, from the tap to the monitor.
  assumes both ends run on ref_clk.
*/
`timescale 1ns/1ns
interface edge_if;
  logic rise;
  logic fall;
  modport source (output rise, output fall);
  modport sink (input rise, input fall);
endinterface

// ==== logic/clock_edge_tap.sv ====
/*
  synchronises the seven clock sources and reports edges of the selected one.
  assumes every source toggles well below half the ref_clk rate.
*/
`timescale 1ns/1ns
`include "monitor_cfg.svh"
module clock_edge_tap
  import monitor_pkg::*;
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [6:0] sources,
  input wire logic [2:0] sel,
  edge_if.source tap
);
  tap_state_type s;
  tap_state_type next_s;
  logic [6:0] stable;

  always_comb
  begin
    next_s = s;
    next_s.stage1 = sources;
    next_s.stage2 = s.stage1;
    next_s.stage3 = s.stage2;
    // a level counts only once stages two and three agree
    stable = ~(s.stage2 ^ s.stage3);
    next_s.seen = (stable & s.stage3) | (~stable & s.seen);
    next_s.rise = 1'b0;
    next_s.fall = 1'b0;
    if (sel < 3'(`SRC_COUNT))
    begin
      next_s.rise = stable[sel] & s.stage3[sel] & ~s.seen[sel];
      next_s.fall = stable[sel] & ~s.stage3[sel] & s.seen[sel];
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      s <= '0;
    else
      s <= next_s;
  end

  assign tap.rise = s.rise;
  assign tap.fall = s.fall;

endmodule // clock_edge_tap

// ==== logic/clock_frequency_accuracy_monitor.sv ====
/*
  clock frequency accuracy monitor: divides a reference and a measurement
  source, counts measurement ticks over one reference period and checks the
  count against two limits.
  assumes sources are slow beside ref_clk and software holds settings stable
  while measure_enable is high.
*/
`timescale 1ns/1ns
`include "monitor_cfg.svh"
module clock_frequency_accuracy_monitor
  import monitor_pkg::*;
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic main_osc,
  input wire logic sub_clock,
  input wire logic high_speed_internal_osc,
  input wire logic mid_speed_internal_osc,
  input wire logic low_speed_internal_osc,
  input wire logic peripheral_bus_clock,
  input wire logic watchdog_oscillator,
  input wire logic measure_enable,
  input wire logic continuous_mode,
  input wire logic [2:0] ref_source_sel,
  input wire logic [1:0] ref_div_sel,
  input wire logic [1:0] ref_edge_sel,
  input wire logic [1:0] ref_filter_sel,
  input wire logic [2:0] meas_source_sel,
  input wire logic [1:0] meas_div_sel,
  input wire logic [15:0] upper_limit,
  input wire logic [15:0] lower_limit,
  input wire logic meas_end_irq_enable,
  input wire logic freq_err_irq_enable,
  input wire logic overflow_irq_enable,
  input wire logic flag_clear,
  output logic [15:0] count_value,
  output logic [15:0] count_result,
  output logic measuring,
  output logic meas_end_flag,
  output logic freq_err_flag,
  output logic overflow_flag,
  output logic meas_end_irq,
  output logic freq_err_irq,
  output logic overflow_irq
);
  monitor_state_type s;
  monitor_state_type next_s;
  logic [6:0] sources;
  logic hit;
  logic tick;
  logic in_range;

  edge_if ref_edges ();
  edge_if meas_edges ();

  function automatic logic [11:0] ref_half(input logic [1:0] sel);
    logic [11:0] half;
    half = `REF_HALF_8192;
    if (sel == `REF_DIV_32)
      half = `REF_HALF_32;
    else if (sel == `REF_DIV_128)
      half = `REF_HALF_128;
    else if (sel == `REF_DIV_1024)
      half = `REF_HALF_1024;
    return half;
  endfunction

  function automatic logic [4:0] meas_term(input logic [1:0] sel);
    logic [4:0] term;
    term = `MEAS_TERM_32;
    if (sel == `MEAS_DIV_1)
      term = `MEAS_TERM_1;
    else if (sel == `MEAS_DIV_4)
      term = `MEAS_TERM_4;
    else if (sel == `MEAS_DIV_8)
      term = `MEAS_TERM_8;
    return term;
  endfunction

  function automatic logic [3:0] filter_term(input logic [1:0] sel);
    logic [3:0] term;
    term = `FILTER_TERM_DIV16;
    if (sel == `FILTER_FULL)
      term = `FILTER_TERM_FULL;
    else if (sel == `FILTER_DIV4)
      term = `FILTER_TERM_DIV4;
    return term;
  endfunction

  assign sources = {watchdog_oscillator, peripheral_bus_clock,
                    low_speed_internal_osc, mid_speed_internal_osc,
                    high_speed_internal_osc, sub_clock, main_osc};

  clock_edge_tap ref_tap
  (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .sources(sources),
    .sel(ref_source_sel),
    .tap(ref_edges.source)
  );

  clock_edge_tap meas_tap
  (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .sources(sources),
    .sel(meas_source_sel),
    .tap(meas_edges.source)
  );

  always_comb
  begin
    next_s = s;
    next_s.meas_end_irq = 1'b0;
    next_s.freq_err_irq = 1'b0;
    next_s.overflow_irq = 1'b0;
    hit = 1'b0;
    tick = 1'b0;
    in_range = 1'b0;
    // clear first so that an event in the same cycle wins
    if (flag_clear)
    begin
      next_s.meas_end_flag = 1'b0;
      next_s.freq_err_flag = 1'b0;
      next_s.overflow_flag = 1'b0;
    end
    // divided reference is a square wave, half a period per toggle
    if (ref_edges.rise)
    begin
      if (s.ref_div >= ref_half(ref_div_sel))
      begin
        next_s.ref_div = 12'h000;
        next_s.ref_div_level = ~s.ref_div_level;
      end
      else
        next_s.ref_div = s.ref_div + 12'h001;
    end
    if (meas_edges.rise)
    begin
      if (s.meas_div >= meas_term(meas_div_sel))
      begin
        next_s.meas_div = 5'h00;
        tick = 1'b1;
      end
      else
        next_s.meas_div = s.meas_div + 5'h01;
    end
    // filter takes a level only after two equal samples in a row
    if (ref_filter_sel == `FILTER_OFF)
      next_s.ref_level = s.ref_div_level;
    else if (meas_edges.rise)
    begin
      if (s.filt_div >= filter_term(ref_filter_sel))
      begin
        next_s.filt_div = 4'h0;
        next_s.filt_sample = s.ref_div_level;
        if (s.ref_div_level == s.filt_sample)
          next_s.ref_level = s.ref_div_level;
      end
      else
        next_s.filt_div = s.filt_div + 4'h1;
    end
    if (ref_edge_sel == `EDGE_RISE)
      hit = next_s.ref_level & ~s.ref_level;
    else if (ref_edge_sel == `EDGE_FALL)
      hit = ~next_s.ref_level & s.ref_level;
    else if (ref_edge_sel == `EDGE_BOTH)
      hit = next_s.ref_level ^ s.ref_level;
    if (!measure_enable)
    begin
      next_s.phase = PHASE_IDLE;
      next_s.done = 1'b0;
      next_s.count = `COUNT_RESET;
    end
    else
    begin
      case (s.phase)
        PHASE_IDLE:
        begin
          // a finished single measurement waits for enable to drop
          if (!s.done)
            next_s.phase = PHASE_ARM;
        end
        PHASE_ARM:
        begin
          if (hit)
          begin
            next_s.phase = PHASE_COUNT;
            next_s.count = `COUNT_RESET;
          end
        end
        PHASE_COUNT:
        begin
          if (hit)
          begin
            // a tick landing on the closing edge is dropped
            next_s.result = s.count;
            in_range = (s.count <= upper_limit) &&
                       (s.count >= lower_limit);
            if (in_range)
            begin
              next_s.meas_end_flag = 1'b1;
              next_s.meas_end_irq = meas_end_irq_enable;
            end
            else
            begin
              next_s.freq_err_flag = 1'b1;
              next_s.freq_err_irq = freq_err_irq_enable;
            end
            next_s.count = `COUNT_RESET;
            if (!continuous_mode)
            begin
              next_s.phase = PHASE_IDLE;
              next_s.done = 1'b1;
            end
          end
          else if (tick)
          begin
            if (s.count == `COUNT_MAX)
            begin
              next_s.overflow_flag = 1'b1;
              next_s.overflow_irq = overflow_irq_enable;
            end
            next_s.count = s.count + 16'h0001;
          end
        end
        default:
          next_s.phase = PHASE_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      s <= '{phase: PHASE_IDLE, default: '0};
    else
      s <= next_s;
  end

  assign count_value = s.count;
  assign count_result = s.result;
  assign measuring = (s.phase != PHASE_IDLE);
  assign meas_end_flag = s.meas_end_flag;
  assign freq_err_flag = s.freq_err_flag;
  assign overflow_flag = s.overflow_flag;
  assign meas_end_irq = s.meas_end_irq;
  assign freq_err_irq = s.freq_err_irq;
  assign overflow_irq = s.overflow_irq;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  ovf_request_gate_a: assert property (
    overflow_irq |-> $past(overflow_irq_enable) && overflow_flag)
    else $error("overflow request without enable");
  ferr_request_gate_a: assert property (
    freq_err_irq |-> $past(freq_err_irq_enable) && freq_err_flag)
    else $error("frequency error request without enable");
  upper_bound_a: assert property (
    meas_end_irq |-> count_result <= $past(upper_limit))
    else $error("measurement end above upper limit");
  lower_bound_a: assert property (
    meas_end_irq |-> count_result >= $past(lower_limit))
    else $error("measurement end below lower limit");
  ferr_outside_a: assert property (
    freq_err_irq |-> (count_result > $past(upper_limit)) ||
                     (count_result < $past(lower_limit)))
    else $error("frequency error with count in range");
  end_request_gate_a: assert property (
    meas_end_irq |-> $past(meas_end_irq_enable) && meas_end_flag)
    else $error("measurement end request without enable");
  ovf_wraps_a: assert property (
    overflow_irq |-> count_value == 16'h0000 &&
                     $past(count_value) == `COUNT_MAX)
    else $error("overflow not at counter maximum");
  single_stops_a: assert property (
    (meas_end_irq || freq_err_irq) && !$past(continuous_mode)
    |-> !measuring ##1 !measuring)
    else $error("single mode did not stop");
  count_steps_a: assert property (
    count_value != $past(count_value)
    |-> count_value == 16'($past(count_value) + 16'h0001) ||
        count_value == 16'h0000)
    else $error("counter moved by more than one");
  idle_count_a: assert property (
    !measuring |-> count_value == 16'h0000)
    else $error("counter not cleared while idle");

endmodule // clock_frequency_accuracy_monitor

// ==== verif/clock_source_model.sv ====
/*
  model of the seven on-chip clock sources feeding the monitor: each one
  toggles after its own number of ref_clk cycles.
  assumes every half period is at least 3 ref_clk cycles, so the monitor's
  synchronisers can see every level.
*/
`timescale 1ns/1ns
module clock_source_model
#(
  parameter logic [6:0][7:0] half_cycles = {7{8'h03}}
)
(
  input wire logic ref_clk,
  output logic [6:0] sources
);
  logic [6:0][7:0] tick;

  initial
  begin
    sources = 7'h00;
    tick = '0;
  end

  // free running: the sources do not stop in reset, as real oscillators
  always @(negedge ref_clk)
  begin
    for (int i = 0; i < 7; i++)
    begin
      if (tick[i] + 8'h01 >= half_cycles[i])
      begin
        tick[i] <= 8'h00;
        sources[i] <= ~sources[i];
      end
      else
        tick[i] <= tick[i] + 8'h01;
    end
  end
endmodule // clock_source_model

// ==== verif/clock_frequency_accuracy_monitor_tb.sv ====
/*
  self-checking bench of the clock frequency accuracy monitor.
  assumes the source model in this folder; expected counts come from the
  source half periods, with one tick of slack for edge alignment.
*/
`timescale 1ns/1ns
`include "monitor_cfg.svh"
module clock_frequency_accuracy_monitor_tb;
  import monitor_pkg::*;
  // main, sub, high, mid, low, bus, watchdog from bit 0 up
  localparam logic [6:0][7:0] half =
    {8'h0a, 8'h04, 8'h1e, 8'h05, 8'h03, 8'h28, 8'h14};
  localparam logic [3:0][15:0] ref_n = {16'h2000, 16'h0400, 16'h0080, 16'h0020};
  localparam logic [3:0][15:0] meas_m = {16'h0020, 16'h0008, 16'h0004, 16'h0001};
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [6:0] sources;
  logic measure_enable = 1'b0;
  logic continuous_mode = 1'b0;
  logic [2:0] ref_source_sel = 3'h0;
  logic [1:0] ref_div_sel = 2'h0;
  logic [1:0] ref_edge_sel = 2'h0;
  logic [1:0] ref_filter_sel = 2'h0;
  logic [2:0] meas_source_sel = 3'h0;
  logic [1:0] meas_div_sel = 2'h0;
  logic [15:0] upper_limit = 16'hffff;
  logic [15:0] lower_limit = 16'h0000;
  logic meas_end_irq_enable = 1'b0;
  logic freq_err_irq_enable = 1'b0;
  logic overflow_irq_enable = 1'b0;
  logic flag_clear = 1'b0;
  logic [15:0] count_value;
  logic [15:0] count_result;
  logic measuring;
  logic meas_end_flag;
  logic freq_err_flag;
  logic overflow_flag;
  logic meas_end_irq;
  logic freq_err_irq;
  logic overflow_irq;
  int fail_count = 0;
  int cmp_count = 0;

  always #2 ref_clk = ~ref_clk;

  clock_source_model #(.half_cycles(half)) i_sources
  (
    .ref_clk(ref_clk),
    .sources(sources)
  );

  clock_frequency_accuracy_monitor i_dut
  (
    .ref_clk(ref_clk), .sys_rst(sys_rst),
    .main_osc(sources[0]), .sub_clock(sources[1]),
    .high_speed_internal_osc(sources[2]), .mid_speed_internal_osc(sources[3]),
    .low_speed_internal_osc(sources[4]), .peripheral_bus_clock(sources[5]),
    .watchdog_oscillator(sources[6]), .measure_enable(measure_enable),
    .continuous_mode(continuous_mode), .ref_source_sel(ref_source_sel),
    .ref_div_sel(ref_div_sel), .ref_edge_sel(ref_edge_sel),
    .ref_filter_sel(ref_filter_sel), .meas_source_sel(meas_source_sel),
    .meas_div_sel(meas_div_sel), .upper_limit(upper_limit),
    .lower_limit(lower_limit), .meas_end_irq_enable(meas_end_irq_enable),
    .freq_err_irq_enable(freq_err_irq_enable),
    .overflow_irq_enable(overflow_irq_enable), .flag_clear(flag_clear),
    .count_value(count_value), .count_result(count_result),
    .measuring(measuring), .meas_end_flag(meas_end_flag),
    .freq_err_flag(freq_err_flag), .overflow_flag(overflow_flag),
    .meas_end_irq(meas_end_irq), .freq_err_irq(freq_err_irq),
    .overflow_irq(overflow_irq)
  );

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic check(input string name, input logic [15:0] seen,
    input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // one tick of slack: a tick on the closing edge is dropped
  function automatic logic [15:0] near(input logic [15:0] seen,
    input logic [15:0] exp);
    if (seen >= exp - 16'h0001 && seen <= exp + 16'h0001)
      return exp;
    return seen;
  endfunction

  function automatic logic [15:0] cnt(int rs, int n, int ms, int m, int both);
    int pr;
    pr = (2 - both) * n * int'(half[rs]);
    return 16'(pr / (2 * m * int'(half[ms])));
  endfunction

  task automatic wait_flags(output logic [2:0] irq);
    int n;
    irq = 3'h0;
    n = 0;
    while (meas_end_flag !== 1'b1 && freq_err_flag !== 1'b1 && n < 60000)
    begin
      @(negedge ref_clk);
      irq = irq | {meas_end_irq, freq_err_irq, overflow_irq};
      n++;
    end
  endtask

  task automatic measure(input logic [2:0] rs, input logic [1:0] rd,
    input logic [1:0] re, input logic [1:0] rf, input logic [2:0] ms,
    input logic [1:0] md, input logic [15:0] lo, input logic [15:0] up,
    input logic [2:0] en, input logic cont, input logic [15:0] exp);
    logic [2:0] irq;
    logic ok;
    @(negedge ref_clk);
    {ref_source_sel, ref_div_sel, ref_edge_sel, ref_filter_sel} =
      {rs, rd, re, rf};
    {meas_source_sel, meas_div_sel, continuous_mode} = {ms, md, cont};
    {lower_limit, upper_limit} = {lo, up};
    {meas_end_irq_enable, freq_err_irq_enable, overflow_irq_enable} = en;
    flag_clear = 1'b1;
    @(negedge ref_clk);
    flag_clear = 1'b0;
    measure_enable = 1'b1;
    wait_flags(irq);
    ok = exp <= up && exp >= lo;
    check("count_result", near(count_result, exp), exp);
    check("meas_end_flag", 16'(meas_end_flag), 16'(ok));
    check("freq_err_flag", 16'(freq_err_flag), 16'(!ok));
    check("meas_end_irq", 16'(irq[2]), 16'(ok & en[2]));
    check("freq_err_irq", 16'(irq[1]), 16'(!ok & en[1]));
    check("overflow_irq", 16'(irq[0]), 16'h0000);
    check("overflow_flag", 16'(overflow_flag), 16'h0000);
    check("measuring", 16'(measuring), 16'(cont));
    check("count_value", count_value, 16'h0000);
    if (!cont)
      measure_enable = 1'b0;
  endtask

  initial
  begin
    repeat (110000) @(posedge ref_clk);
    fail_count++;
    report_and_stop;
  end

  initial
  begin : main_seq
    logic [2:0] irq;
    repeat (10) @(negedge ref_clk);
    sys_rst = 1'b0;
    for (int i = 0; i < 7; i++)
      measure(3'(i), 2'h0, `EDGE_RISE, `FILTER_OFF, 3'((i + 2) % 7), 2'h0,
        16'h0000, 16'hffff, 3'h7, 1'b0,
        cnt(i, 32, (i + 2) % 7, 1, 0));
    // irqs disabled here, so flags alone must show the result
    for (int k = 0; k < 4; k++)
      measure(3'h2, 2'(k), `EDGE_BOTH, `FILTER_OFF, 3'h5, 2'(k), 16'h0000,
        16'hffff, 3'h0, 1'b0,
        cnt(2, int'(ref_n[k]), 5, int'(meas_m[k]), 1));
    // 640-cycle reference half period keeps filter latency constant
    for (int f = 0; f < 4; f++)
      measure(3'h0, 2'h0, 2'(f % 3), 2'(f), 3'h5, 2'h0, 16'h0000, 16'hffff,
        3'h7, 1'b0, cnt(0, 32, 5, 1, int'(f % 3 == 2)));
    measure(3'h2, 2'h0, `EDGE_RISE, `FILTER_OFF, 3'h5, 2'h0, 16'h0014,
      16'h001c, 3'h7, 1'b0, 16'h0018);
    measure(3'h2, 2'h0, `EDGE_RISE, `FILTER_OFF, 3'h5, 2'h0, 16'h0010,
      16'h0015, 3'h7, 1'b0, 16'h0018);
    measure(3'h2, 2'h0, `EDGE_RISE, `FILTER_OFF, 3'h5, 2'h0, 16'h001c,
      16'h0030, 3'h0, 1'b0, 16'h0018);
    measure(3'h2, 2'h0, `EDGE_RISE, `FILTER_OFF, 3'h5, 2'h0, 16'h0000,
      16'hffff, 3'h7, 1'b1, 16'h0018);
    flag_clear = 1'b1;
    @(negedge ref_clk);
    flag_clear = 1'b0;
    wait_flags(irq);
    check("restart_flag", 16'(meas_end_flag), 16'h0001);
    check("restart_irq", 16'(irq[2]), 16'h0001);
    check("restart_count", near(count_result, 16'h0018),
      16'h0018);
    measure_enable = 1'b0;
    repeat (4) @(negedge ref_clk);
    check("stopped", 16'(measuring), 16'h0000);
    // code 7 selects no source: armed forever, no result
    flag_clear = 1'b1;
    ref_source_sel = 3'h7;
    @(negedge ref_clk);
    flag_clear = 1'b0;
    measure_enable = 1'b1;
    repeat (400) @(negedge ref_clk);
    check("no_source", 16'({measuring, meas_end_flag, freq_err_flag}),
      16'h0004);
    report_and_stop;
  end
endmodule // clock_frequency_accuracy_monitor_tb
